// ==== rtl/spc_stop_ctrl.sv ====
// stop mode power controller: mode sequencing and peripheral clock gating
// ****************************************************************
// Notes on behaviour
// ****************************************************************
// Notes on behaviour
// R1: a stop instruction from the cpu puts the device into stop mode
// R2: subsystem oscillator keeps its pre-stop running state throughout stop
// R3: port levels and configuration are frozen at their pre-stop values
// R4: rtc, interval timer, timer j, buzzer, dac, event link, por, vdet, keys run
// R5: watchdog runs or halts in stop according to a configuration input
// R6: a/d converter runs in stop only via autonomous wake mode
// R7: comparator runs in stop only with filter off and external reference
// R8: serial array unit runs in stop only via autonomous wake mode
// R9: two-wire unit can wake the device on own address match
// R10: transfer controller keeps accepting activation sources during stop
// R11: timer array, timer d and timer g are blocked in stop
// R12: crc, illegal access, ram guard and register guard stop in stop
// R13: peripheral_enable_a holds adc, rtc, two-wire, serial array, timer array enables
// R14: peripheral_enable_b holds dac, timer g, comparator, transfer, timer j, timer d0
// R15: subclock_supply_control holds a low-power bit for subclock-cpu stop/halt
// R16: subclock_supply_control selects the rtc, interval timer, timer j clock
// R17: autonomous wake only for serial, adc, transfer; only on high-speed cpu clock
// R18: main oscillator halted and cpu execution stopped for all of stop
// R19: ram retained in stop; external interrupts end stop mode
`timescale 1ns/100ps
module spc_stop_ctrl #(
  parameter int unsigned PORT_WIDTH = 8,
  parameter logic [7:0] WAKE_WAIT = spc_pkg::WAKE_WAIT_CYCLES
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // cpu side
  input wire logic stop_instr_i,
  input wire logic cpu_on_subclock_i,
  input wire logic cpu_on_hs_osc_i,
  output logic cpu_run_o,
  output logic stop_mode_o,
  // clock supply configuration writes
  input wire logic cfg_we_i,
  input wire logic [7:0] peripheral_enable_a_i,
  input wire logic [7:0] peripheral_enable_b_i,
  input wire logic [1:0] subclock_supply_control_i,
  output logic [7:0] peripheral_enable_a_o,
  output logic [7:0] peripheral_enable_b_o,
  output logic [1:0] subclock_supply_control_o,
  // options
  input wire logic wdt_run_in_stop_i,
  input wire logic cmp_filter_used_i,
  input wire logic cmp_ext_ref_i,
  input wire logic subosc_enable_i,
  // autonomous wake requests
  input wire logic csi_autonomous_wake_mode_i,
  input wire logic adc_autonomous_wake_mode_i,
  input wire logic dtc_autonomous_wake_mode_i,
  // wake sources and transfer trigger from pins
  input wire logic ext_irq_i,
  input wire logic key_irq_i,
  input wire logic two_wire_addr_match_i,
  input wire logic transfer_ctrl_trigger_i,
  // port retention
  input wire logic [PORT_WIDTH-1:0] port_out_i,
  input wire logic [PORT_WIDTH-1:0] port_dir_i,
  output logic [PORT_WIDTH-1:0] port_out_o,
  output logic [PORT_WIDTH-1:0] port_dir_o,
  // clock and function gates
  output logic main_osc_en_o,
  output logic subosc_en_o,
  output logic subclock_low_power_o,
  output logic slow_timer_clock_select_o,
  output logic [spc_pkg::RUN_WIDTH-1:0] always_run_en_o,
  output logic [spc_pkg::HLT_WIDTH-1:0] halt_fn_en_o,
  output logic wdt_en_o,
  output logic adc_en_o,
  output logic adc_autonomous_wake_mode_o,
  output logic comparator_en_o,
  output logic serial_array_en_o,
  output logic serial_autonomous_wake_mode_o,
  output logic two_wire_en_o,
  output logic two_wire_wake_o,
  output logic transfer_ctrl_accept_o,
  output logic timer_array_en_o,
  output logic timer_d_en_o,
  output logic timer_g_en_o,
  output logic ram_retain_o
);
  // ****************************************************************
  // parameter checks
  // ****************************************************************
  initial begin
    if (PORT_WIDTH < 1) $error("spc_stop_ctrl port width must be at least one");
    if (WAKE_WAIT == 8'h00) $error("spc_stop_ctrl wake wait must be nonzero");
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  // paired units share one gate, so either supply enable keeps it clocked
  function automatic logic either_on(input logic [7:0] val, input int unsigned lo,
                                     input int unsigned hi);
    return val[lo] || val[hi];
  endfunction
  // a unit runs when supplied, and in stop only while its stop condition holds
  function automatic logic stop_gate(input logic supply_on, input logic stopped,
                                     input logic allowed);
    return supply_on && (!stopped || allowed);
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // external wake sources are asynchronous; every one passes two flops
  logic [3:0] pin_raw;
  logic [3:0] pin_sync;
  assign pin_raw = {transfer_ctrl_trigger_i, two_wire_addr_match_i, key_irq_i, ext_irq_i};
  spc_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .async_i(pin_raw),
    .sync_o(pin_sync)
  );
  wire ext_irq_s = pin_sync[0];
  wire key_irq_s = pin_sync[1];
  wire addr_match_s = pin_sync[2];
  wire dtc_trig_s = pin_sync[3];

  // ****************************************************************
  // clock supply registers
  // ****************************************************************
  logic [7:0] pea_q;
  logic [7:0] pea_d;
  logic [7:0] peb_q;
  logic [7:0] peb_d;
  logic [1:0] ssc_q;
  logic [1:0] ssc_d;
  // writes are ignored in stop: the cpu is not executing then anyway
  logic cfg_take;
  assign cfg_take = cfg_we_i && cpu_run_o;
  // the two top bits of the second enable set are unused and read as zero
  logic [7:0] peb_write;
  assign peb_write = peripheral_enable_b_i & 8'h3F;
  assign pea_d = cfg_take ? peripheral_enable_a_i : pea_q; // R13
  assign peb_d = cfg_take ? peb_write : peb_q; // R14
  assign ssc_d = cfg_take ? subclock_supply_control_i : ssc_q; // R15 R16

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pea_q <= spc_pkg::PEA_RESET;
      peb_q <= spc_pkg::PEB_RESET;
      ssc_q <= spc_pkg::SSC_RESET;
    end else begin
      pea_q <= pea_d;
      peb_q <= peb_d;
      ssc_q <= ssc_d;
    end
  end

  assign peripheral_enable_a_o = pea_q;
  assign peripheral_enable_b_o = peb_q;
  assign subclock_supply_control_o = ssc_q;

  // ****************************************************************
  // mode sequencer
  // ****************************************************************
  spc_pkg::spc_state_t state_q;
  spc_pkg::spc_state_t state_d;
  logic [7:0] wait_q;
  logic [7:0] wait_d;
  logic wake_req;
  // only unit 0 carries the address matcher that may end stop
  logic tw_match;
  assign tw_match = addr_match_s && pea_q[spc_pkg::PEA_TWO_WIRE0]; // R9
  // wake by external or key interrupt, or own address match on the two-wire unit
  assign wake_req = ext_irq_s || key_irq_s || tw_match; // R19 R9

  always_comb begin
    state_d = state_q;
    wait_d = wait_q;
    case (state_q)
      spc_pkg::SPC_RUN: begin
        if (stop_instr_i) begin
          state_d = spc_pkg::SPC_ENTER; // R1
        end
      end
      spc_pkg::SPC_ENTER: begin
        state_d = spc_pkg::SPC_STOP; // R1
      end
      spc_pkg::SPC_STOP: begin
        if (wake_req) begin
          state_d = spc_pkg::SPC_WAKE; // R19
          wait_d = WAKE_WAIT;
        end
      end
      spc_pkg::SPC_WAKE: begin
        // main oscillator needs settling time before the cpu restarts
        if (wait_q == 8'h01) begin
          state_d = spc_pkg::SPC_RUN;
          wait_d = 8'h00;
        end else begin
          wait_d = wait_q - 8'h01;
        end
      end
      default: begin
        state_d = spc_pkg::SPC_RUN;
        wait_d = 8'h00;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= spc_pkg::SPC_RUN;
      wait_q <= 8'h00;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
    end
  end

  logic in_stop;
  assign in_stop = (state_q == spc_pkg::SPC_STOP);
  assign stop_mode_o = in_stop;
  assign cpu_run_o = (state_q == spc_pkg::SPC_RUN); // R18
  assign main_osc_en_o = !in_stop; // R18
  assign ram_retain_o = in_stop; // R19

  // ****************************************************************
  // state captured on entry
  // ****************************************************************
  logic subosc_q;
  logic lowpwr_q;
  logic [PORT_WIDTH-1:0] pout_q;
  logic [PORT_WIDTH-1:0] pdir_q;
  logic snap;
  assign snap = (state_q == spc_pkg::SPC_ENTER);
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      subosc_q <= 1'b0;
      lowpwr_q <= 1'b0;
      pout_q <= '0;
      pdir_q <= '0;
    end else if (snap || cpu_run_o) begin
      subosc_q <= subosc_enable_i; // R2
      lowpwr_q <= cpu_on_subclock_i && ssc_q[spc_pkg::SSC_LOW_POWER]; // R15
      pout_q <= port_out_i; // R3
      pdir_q <= port_dir_i; // R3
    end
  end

  // outputs during stop come from the frozen copy
  assign subosc_en_o = in_stop ? subosc_q : subosc_enable_i; // R2
  assign port_out_o = pout_q; // R3
  assign port_dir_o = pdir_q; // R3
  assign subclock_low_power_o = lowpwr_q; // R15
  assign slow_timer_clock_select_o = ssc_q[spc_pkg::SSC_SLOW_TIMER_CLK]; // R16

  // ****************************************************************
  // peripheral gating
  // ****************************************************************
  logic rtc_on;
  assign rtc_on = pea_q[spc_pkg::PEA_RTC];
  logic timer_j_on;
  assign timer_j_on = peb_q[spc_pkg::PEB_TIMER_J];
  logic dac_on;
  assign dac_on = peb_q[spc_pkg::PEB_DAC];
  // always-running group ignores stop; supply enables still apply
  assign always_run_en_o = {1'b1, 1'b1, 1'b1, 1'b1, dac_on, 1'b1, timer_j_on, 1'b1, rtc_on}; // R4
  assign halt_fn_en_o = in_stop ? '0 : {spc_pkg::HLT_WIDTH{1'b1}}; // R12
  assign wdt_en_o = !in_stop || wdt_run_in_stop_i; // R5

  // autonomous wake only for the permitted units, and only on the high-speed clock
  logic aw_ok;
  assign aw_ok = cpu_on_hs_osc_i && !cpu_on_subclock_i; // R17
  logic sa_on;
  assign sa_on = either_on(pea_q, spc_pkg::PEA_SERIAL_ARRAY0, spc_pkg::PEA_SERIAL_ARRAY1);
  logic ta_on;
  assign ta_on = either_on(pea_q, spc_pkg::PEA_TIMER_ARRAY0, spc_pkg::PEA_TIMER_ARRAY1);
  logic adc_aw;
  logic csi_aw;
  logic dtc_aw;
  assign adc_aw = aw_ok && adc_autonomous_wake_mode_i && pea_q[spc_pkg::PEA_ADC]; // R17
  assign csi_aw = aw_ok && csi_autonomous_wake_mode_i && sa_on; // R17
  assign dtc_aw = aw_ok && dtc_autonomous_wake_mode_i && peb_q[spc_pkg::PEB_TRANSFER_CTRL]; // R17
  assign adc_en_o = stop_gate(pea_q[spc_pkg::PEA_ADC], in_stop, adc_aw); // R6
  assign adc_autonomous_wake_mode_o = in_stop && adc_aw; // R6
  assign comparator_en_o = stop_gate(peb_q[spc_pkg::PEB_COMPARATOR], in_stop,
                                     !cmp_filter_used_i && cmp_ext_ref_i); // R7
  assign serial_array_en_o = stop_gate(sa_on, in_stop, csi_aw); // R8
  assign serial_autonomous_wake_mode_o = in_stop && csi_aw; // R8

  logic tw_on;
  assign tw_on = either_on(pea_q, spc_pkg::PEA_TWO_WIRE0, spc_pkg::PEA_TWO_WIRE1);
  // in stop the two-wire unit only keeps its address matcher alive
  assign two_wire_en_o = stop_gate(tw_on, in_stop, 1'b0);
  assign two_wire_wake_o = in_stop && tw_match; // R9
  // trigger acceptance stays open in stop; transfers themselves wait for wake
  assign transfer_ctrl_accept_o = peb_q[spc_pkg::PEB_TRANSFER_CTRL]
                                  && (!in_stop || dtc_trig_s || dtc_aw); // R10
  // blocked timers lose their clock outright, whatever their supply enable says
  assign timer_array_en_o = stop_gate(ta_on, in_stop, 1'b0); // R11
  assign timer_d_en_o = stop_gate(peb_q[spc_pkg::PEB_TIMER_D0], in_stop, 1'b0); // R11
  assign timer_g_en_o = stop_gate(peb_q[spc_pkg::PEB_TIMER_G], in_stop, 1'b0); // R11
endmodule // spc_stop_ctrl

// ==== rtl/spc_pkg.sv ====
// constants shared by the stop mode power controller
package spc_pkg;
  // peripheral_enable_a field positions
  localparam int unsigned PEA_TIMER_ARRAY0 = 0;
  localparam int unsigned PEA_TIMER_ARRAY1 = 1;
  localparam int unsigned PEA_SERIAL_ARRAY0 = 2;
  localparam int unsigned PEA_SERIAL_ARRAY1 = 3;
  localparam int unsigned PEA_TWO_WIRE0 = 4;
  localparam int unsigned PEA_TWO_WIRE1 = 5;
  localparam int unsigned PEA_ADC = 6;
  localparam int unsigned PEA_RTC = 7;
  // peripheral_enable_b field positions
  localparam int unsigned PEB_TIMER_J = 0;
  localparam int unsigned PEB_TIMER_D0 = 1;
  localparam int unsigned PEB_TIMER_G = 2;
  localparam int unsigned PEB_COMPARATOR = 3;
  localparam int unsigned PEB_TRANSFER_CTRL = 4;
  localparam int unsigned PEB_DAC = 5;
  // subclock_supply_control field positions
  localparam int unsigned SSC_SLOW_TIMER_CLK = 0;
  localparam int unsigned SSC_LOW_POWER = 1;
  // reset values
  localparam logic [7:0] PEA_RESET = 8'h00;
  localparam logic [7:0] PEB_RESET = 8'h00;
  localparam logic [1:0] SSC_RESET = 2'h0;
  // gate vector bit positions for always-running functions
  localparam int unsigned RUN_RTC = 0;
  localparam int unsigned RUN_INTERVAL = 1;
  localparam int unsigned RUN_TIMER_J = 2;
  localparam int unsigned RUN_BUZZER = 3;
  localparam int unsigned RUN_DAC = 4;
  localparam int unsigned RUN_EVENT_LINK = 5;
  localparam int unsigned RUN_POR = 6;
  localparam int unsigned RUN_VDET = 7;
  localparam int unsigned RUN_KEY = 8;
  localparam int unsigned RUN_WIDTH = 9;
  // gate vector bit positions for functions stopped in stop mode
  localparam int unsigned HLT_CRC = 0;
  localparam int unsigned HLT_ILLEGAL_ACCESS = 1;
  localparam int unsigned HLT_RAM_GUARD = 2;
  localparam int unsigned HLT_REG_GUARD = 3;
  localparam int unsigned HLT_WIDTH = 4;
  // oscillator wake-up wait in main clock cycles
  localparam logic [7:0] WAKE_WAIT_CYCLES = 8'h08;
  typedef enum logic [1:0] {
    SPC_RUN,
    SPC_ENTER,
    SPC_STOP,
    SPC_WAKE
  } spc_state_t;
endpackage

// ==== rtl/spc_sync.sv ====
// two flip-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/100ps
module spc_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  initial begin
    if (WIDTH < 1) $error("spc_sync width must be at least one");
  end
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end
  assign sync_o = sync_q;
endmodule // spc_sync

// ==== bench/spc_far_cpu.sv ====
// cpu core model that issues the stop instruction on request
`timescale 1ns/100ps
module spc_far_cpu (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // bench control
  input wire logic exec_i,
  input wire logic [3:0] lag_i,
  input wire logic hs_sel_i,
  // controller side
  input wire logic cpu_run_i,
  output logic stop_instr_o,
  output logic cpu_on_hs_osc_o,
  output logic cpu_on_subclock_o
);
  logic [3:0] wait_q;
  assign cpu_on_hs_osc_o = hs_sel_i;
  assign cpu_on_subclock_o = !hs_sel_i;
  // a halted core executes nothing, so the request only fires while running
  always @(negedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stop_instr_o <= 1'b0;
      wait_q <= 4'h0;
    end else if (stop_instr_o) begin
      stop_instr_o <= 1'b0;
    end else if (exec_i && cpu_run_i) begin
      if (wait_q == lag_i) begin
        stop_instr_o <= 1'b1;
        wait_q <= 4'h0;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule // spc_far_cpu

// ==== bench/spc_stop_ctrl_props.sv ====
// assertion checker for the stop mode power controller ports
`timescale 1ns/100ps
module spc_stop_ctrl_props #(
  parameter int unsigned PORT_WIDTH = 8
) (
  // clock and reset
  input wire logic sys_clk_i, nrst_i,
  // watched ports
  input wire logic stop_instr_i, cpu_run_o, stop_mode_o, main_osc_en_o, subosc_en_o,
  input wire logic [PORT_WIDTH-1:0] port_out_o,
  input wire logic [spc_pkg::RUN_WIDTH-1:0] always_run_en_o,
  input wire logic [spc_pkg::HLT_WIDTH-1:0] halt_fn_en_o,
  input wire logic wdt_run_in_stop_i, wdt_en_o, adc_en_o, adc_autonomous_wake_mode_o,
  input wire logic comparator_en_o, cmp_filter_used_i, cmp_ext_ref_i, ext_irq_i,
  input wire logic timer_array_en_o, timer_d_en_o, timer_g_en_o, ram_retain_o, cfg_we_i,
  input wire logic [7:0] peripheral_enable_a_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // ****************
  // properties
  // ****************
  property p_enter; stop_instr_i && cpu_run_o |=> !cpu_run_o ##1 stop_mode_o; endproperty
  a_enter: assert property (p_enter) else $error("stop entry late");
  property p_subosc; stop_mode_o && $past(stop_mode_o) |-> $stable(subosc_en_o); endproperty
  a_subosc: assert property (p_subosc) else $error("subosc changed");
  property p_ports; stop_mode_o && $past(stop_mode_o) |-> $stable(port_out_o); endproperty
  a_ports: assert property (p_ports) else $error("port changed");
  property p_run; stop_mode_o |-> &always_run_en_o; endproperty
  a_run: assert property (p_run) else $error("always-run gated");
  property p_wdt; stop_mode_o |-> wdt_en_o == wdt_run_in_stop_i; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog option");
  property p_adc; stop_mode_o && adc_en_o |-> adc_autonomous_wake_mode_o; endproperty
  a_adc: assert property (p_adc) else $error("adc outside wake mode");
  property p_cmp; stop_mode_o && comparator_en_o |-> !cmp_filter_used_i && cmp_ext_ref_i;
  endproperty
  a_cmp: assert property (p_cmp) else $error("comparator ran");
  property p_tmr; stop_mode_o |-> !(timer_array_en_o || timer_d_en_o || timer_g_en_o);
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer ran");
  property p_hlt; stop_mode_o |-> halt_fn_en_o == '0; endproperty
  a_hlt: assert property (p_hlt) else $error("guard logic ran");
  property p_osc; stop_mode_o |-> !main_osc_en_o && !cpu_run_o && ram_retain_o; endproperty
  a_osc: assert property (p_osc) else $error("osc or cpu active");
  property p_wake; stop_mode_o && ext_irq_i |-> ##[1:4] !stop_mode_o; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  // the oscillator needs its settling wait before the cpu may resume
  property p_wait; $fell(stop_mode_o) |-> !cpu_run_o [*7] ##[1:4] cpu_run_o; endproperty
  a_wait: assert property (p_wait) else $error("wake wait wrong");
  property p_cfg; !(cfg_we_i && cpu_run_o) |=> $stable(peripheral_enable_a_o); endproperty
  a_cfg: assert property (p_cfg) else $error("config changed");
endmodule // spc_stop_ctrl_props
bind spc_stop_ctrl spc_stop_ctrl_props #(.PORT_WIDTH(PORT_WIDTH)) i_spc_stop_ctrl_props (.*);

// ==== bench/spc_stop_ctrl_test.sv ====
// self-checking testbench for the stop mode power controller
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin fail_count++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module spc_stop_ctrl_test;
  logic sys_clk_i = 1'b0, nrst_i = 1'b0, cfg_we_i = 1'b0, exec = 1'b0, hs_sel = 1'b1;
  logic wdt_run_in_stop_i = 1'b0, cmp_filter_used_i = 1'b0, cmp_ext_ref_i = 1'b0;
  logic subosc_enable_i = 1'b0, csi_autonomous_wake_mode_i = 1'b0, ext_irq_i = 1'b0;
  logic adc_autonomous_wake_mode_i = 1'b0, dtc_autonomous_wake_mode_i = 1'b0;
  logic key_irq_i = 1'b0, two_wire_addr_match_i = 1'b0, transfer_ctrl_trigger_i = 1'b0;
  logic [7:0] peripheral_enable_a_i = 8'h00, peripheral_enable_b_i = 8'h00;
  logic [7:0] port_out_i = 8'h00, port_dir_i = 8'h00;
  logic [1:0] subclock_supply_control_i = 2'h0;
  logic [3:0] lag = 4'h0;
  logic stop_instr_i, cpu_on_subclock_i, cpu_on_hs_osc_i, cpu_run_o, stop_mode_o;
  logic main_osc_en_o, subosc_en_o, subclock_low_power_o, slow_timer_clock_select_o;
  logic wdt_en_o, adc_en_o, adc_autonomous_wake_mode_o, comparator_en_o, serial_array_en_o;
  logic serial_autonomous_wake_mode_o, two_wire_en_o, two_wire_wake_o, transfer_ctrl_accept_o;
  logic timer_array_en_o, timer_d_en_o, timer_g_en_o, ram_retain_o;
  logic [7:0] peripheral_enable_a_o, peripheral_enable_b_o, port_out_o, port_dir_o;
  logic [1:0] subclock_supply_control_o;
  logic [spc_pkg::RUN_WIDTH-1:0] always_run_en_o;
  logic [spc_pkg::HLT_WIDTH-1:0] halt_fn_en_o;
  int fail_count = 0;
  int samples_checked = 0;
  spc_stop_ctrl i_spc_stop_ctrl (.*);
  spc_far_cpu i_spc_far_cpu (.sys_clk_i, .nrst_i, .exec_i(exec), .lag_i(lag), .hs_sel_i(hs_sel),
    .cpu_run_i(cpu_run_o), .stop_instr_o(stop_instr_i), .cpu_on_hs_osc_o(cpu_on_hs_osc_i),
    .cpu_on_subclock_o(cpu_on_subclock_i));
  always #2.5 sys_clk_i = ~sys_clk_i;
  // ****************
  // tasks
  // ****************
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic cfg(input logic [7:0] a, input logic [7:0] b, input logic [1:0] s);
    peripheral_enable_a_i = a;
    peripheral_enable_b_i = b;
    subclock_supply_control_i = s;
    cfg_we_i = 1'b1;
    cyc(1);
    cfg_we_i = 1'b0;
    cyc(1);
  endtask
  // bounded waits: a hung controller must not stall the run
  task automatic wait_sig(input bit run, output int n);
    n = 0;
    while ((run ? cpu_run_o : stop_mode_o) !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****************
  // tests
  // ****************
  initial begin
    int n;
    cyc(8);
    nrst_i = 1'b1;
    cyc(1);
    `CHK("run", 1'b1, cpu_run_o && main_osc_en_o)
    `CHK("pea rst", spc_pkg::PEA_RESET, peripheral_enable_a_o)
    `CHK("peb rst", spc_pkg::PEB_RESET, peripheral_enable_b_o)
    `CHK("ssc rst", spc_pkg::SSC_RESET, subclock_supply_control_o)
    for (int i = 0; i < 8; i++) begin
      hs_sel = !i[2];
      cfg(8'h01 << i, 8'h01 << i, i[1:0]);
      `CHK("pea", 8'h01 << i, peripheral_enable_a_o)
      `CHK("peb", (8'h01 << i) & 8'h3f, peripheral_enable_b_o)
      `CHK("low power", i[1] && i[2], subclock_low_power_o)
      `CHK("ssc", i[1:0], subclock_supply_control_o)
      `CHK("slow clk", i[0], slow_timer_clock_select_o)
    end
    for (int r = 0; r < 3; r++) begin
      cfg((r == 0) ? 8'h80 : ((r == 1) ? 8'hdc : 8'hc0), 8'h39, 2'h0);
      wdt_run_in_stop_i = r[0];
      cmp_filter_used_i = (r == 0);
      cmp_ext_ref_i = 1'b1;
      adc_autonomous_wake_mode_i = (r != 0);
      csi_autonomous_wake_mode_i = (r == 1);
      hs_sel = (r != 2);
      subosc_enable_i = !r[0];
      port_out_i = 8'ha5 ^ r[7:0];
      port_dir_i = 8'h3c;
      lag = r[3:0];
      exec = 1'b1;
      wait_sig(1'b0, n);
      exec = 1'b0;
      `CHK("stop", 1'b1, stop_mode_o)
      port_out_i = 8'h00;
      port_dir_i = 8'hff;
      subosc_enable_i = r[0];
      two_wire_addr_match_i = (r != 0);
      transfer_ctrl_trigger_i = 1'b1;
      cfg(8'hff, 8'hff, 2'h3);
      `CHK("port out", 8'ha5 ^ r[7:0], port_out_o)
      `CHK("port dir", 8'h3c, port_dir_o)
      `CHK("halted", 2'h0, {main_osc_en_o, cpu_run_o})
      `CHK("subosc", !r[0], subosc_en_o)
      `CHK("always run", {spc_pkg::RUN_WIDTH{1'b1}}, always_run_en_o)
      `CHK("wdt", r[0], wdt_en_o)
      `CHK("adc gate", r == 1, adc_en_o)
      `CHK("adc wake", r == 1, adc_autonomous_wake_mode_o)
      `CHK("cmp", r != 0, comparator_en_o)
      `CHK("serial", r == 1, serial_array_en_o)
      `CHK("serial wake", r == 1, serial_autonomous_wake_mode_o)
      `CHK("tw wake", r == 1, two_wire_wake_o)
      `CHK("tw gated", 1'b0, two_wire_en_o)
      `CHK("transfer", 1'b1, transfer_ctrl_accept_o)
      `CHK("timers", 3'h0, {timer_array_en_o, timer_d_en_o, timer_g_en_o})
      `CHK("guards", {spc_pkg::HLT_WIDTH{1'b0}}, halt_fn_en_o)
      `CHK("ram", 1'b1, ram_retain_o)
      if (r == 2) begin
        cyc(10);
        `CHK("no match wake", 1'b1, stop_mode_o)
        key_irq_i = 1'b1;
      end
      if (r == 0) ext_irq_i = 1'b1;
      wait_sig(1'b1, n);
      `CHK("wake span", 1'b1, n >= 9 && n <= 14)
      ext_irq_i = 1'b0;
      key_irq_i = 1'b0;
      two_wire_addr_match_i = 1'b0;
      transfer_ctrl_trigger_i = 1'b0;
      `CHK("cfg refused", (r == 0) ? 8'h80 : ((r == 1) ? 8'hdc : 8'hc0), peripheral_enable_a_o)
    end
    print_verdict;
  end
  initial begin
    #50000;
    fail_count++;
    print_verdict;
  end
endmodule // spc_stop_ctrl_test
